// ---- logic/pidc_controller.sv ----
// process controller: feedback mapping, deviation, three terms, clamp
`timescale 1ns/1ns
// Overview of operation
// - deviation is target minus feedback; output drives feedback toward target
// - sources 0 and 1: forward voltage 0..10 V or current 4..20 mA
// - sources 2 and 3: reverse voltage 10..0 V or current 20..4 mA
// - negative feedback magnitudes are treated as zero
// - proportional term is gain times deviation, gain 0.01 to 10.0
// - integral time 0.1 to 3600 s accumulates deviation; zero disables it
// - derivative term scales deviation change by time 0.01 to 10 s; zero disables
// - output sense selectable forward or reverse
// - target select input off picks primary source, on picks keypad value
// - controller is inhibited while second motor set is selected
// - target and feedback scaled for display by two coefficients
// - feedback low-pass filtered, time 0.0 to 60.0 s
module pidc_controller
#(
    parameter int SAMPLE_CYCLES = pidc_pkg::SAMPLE_CYCLES
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // analog feedback codes
    input wire logic signed [12:0] voltage_feedback_input,
    input wire logic signed [12:0] current_feedback_input,
    // target sources and selects
    input wire logic [11:0] primary_frequency_source,
    input wire logic target_select,
    input wire logic motor2_select,
    // frequency path
    output logic [11:0] freq_demand,
    output logic pid_active
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clip16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clip16

    function automatic logic [11:0] pos12(input logic signed [12:0] v);
        pos12 = v[12] ? 12'h000 : v[11:0];
    endfunction : pos12

    function automatic logic signed [31:0] sat32(input logic signed [31:0] v, input logic signed [31:0] lim);
        sat32 = (v > lim) ? lim : ((v < -lim) ? -lim : v);
    endfunction : sat32

    function automatic logic [15:0] display(input logic [11:0] v, input logic [15:0] ca, input logic [15:0] cb);
        logic [27:0] prod;
        prod = v * ca;
        display = prod[27:12] + cb;
    endfunction : display

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] gain_reg;
    logic [15:0] itime_reg;
    logic [15:0] dtime_reg;
    logic [15:0] filter_reg;
    logic [15:0] keypad_reg;
    logic [15:0] disp_a_reg;
    logic [15:0] disp_b_reg;
    logic [1:0] feedback_source_select;
    logic output_reverse;

    assign feedback_source_select = ctrl_reg[pidc_pkg::CTRL_SRC_LSB +: 2];
    assign output_reverse = ctrl_reg[pidc_pkg::CTRL_REVERSE_BIT];

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl_reg <= pidc_pkg::CTRL_RESET;
            gain_reg <= pidc_pkg::GAIN_RESET;
            itime_reg <= pidc_pkg::ITIME_RESET;
            dtime_reg <= pidc_pkg::DTIME_RESET;
            filter_reg <= pidc_pkg::FILTER_RESET;
            keypad_reg <= 16'h0000;
            disp_a_reg <= pidc_pkg::DISP_A_RESET;
            disp_b_reg <= pidc_pkg::DISP_B_RESET;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                pidc_pkg::REG_CTRL: ctrl_reg <= {12'h000, reg_wdata[3:0]};
                pidc_pkg::REG_GAIN: gain_reg <= clip16(reg_wdata, pidc_pkg::GAIN_MIN, pidc_pkg::GAIN_MAX);
                pidc_pkg::REG_ITIME: itime_reg <= clip16(reg_wdata, 16'h0000, pidc_pkg::ITIME_MAX);
                pidc_pkg::REG_DTIME: dtime_reg <= clip16(reg_wdata, 16'h0000, pidc_pkg::DTIME_MAX);
                pidc_pkg::REG_FILTER: filter_reg <= clip16(reg_wdata, 16'h0000, pidc_pkg::FILTER_MAX);
                pidc_pkg::REG_KEYPAD: keypad_reg <= {4'h0, reg_wdata[11:0]};
                pidc_pkg::REG_DISP_A: disp_a_reg <= reg_wdata;
                pidc_pkg::REG_DISP_B: disp_b_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sample timer
    // ------------------------------------------------------------
    logic [19:0] tick_count_reg;
    logic sample_tick;
    logic calc_strobe_reg;

    assign sample_tick = (tick_count_reg == 20'(SAMPLE_CYCLES - 1));

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tick_count_reg <= 20'h00000;
        else if (sample_tick)
            tick_count_reg <= 20'h00000;
        else
            tick_count_reg <= tick_count_reg + 20'h00001;
    end

    // calculation runs one cycle after the filter has taken its step
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            calc_strobe_reg <= 1'b0;
        else
            calc_strobe_reg <= sample_tick;
    end

    // ------------------------------------------------------------
    // target and feedback mapping
    // ------------------------------------------------------------
    logic [11:0] target_now;
    logic [11:0] volt_pos;
    logic [11:0] curr_pos;
    logic [11:0] curr_scaled;
    logic [23:0] curr_prod;
    logic [11:0] fb_raw;
    logic [11:0] fb_filt;

    assign target_now = target_select ? keypad_reg[11:0] : primary_frequency_source;

    always_comb
    begin
        volt_pos = pos12(voltage_feedback_input);
        curr_pos = pos12(current_feedback_input);
        curr_prod = (curr_pos > pidc_pkg::CURRENT_ZERO_CODE)
            ? (curr_pos - pidc_pkg::CURRENT_ZERO_CODE) * 24'(pidc_pkg::FULL_SCALE) : 24'h000000;
        curr_scaled = (curr_prod / 24'(pidc_pkg::CURRENT_SPAN) > 24'(pidc_pkg::FULL_SCALE))
            ? pidc_pkg::FULL_SCALE : 12'(curr_prod / 24'(pidc_pkg::CURRENT_SPAN));
        unique case (feedback_source_select)
            pidc_pkg::SRC_VOLT_FWD: fb_raw = volt_pos;
            pidc_pkg::SRC_CURR_FWD: fb_raw = curr_scaled;
            pidc_pkg::SRC_VOLT_REV: fb_raw = pidc_pkg::FULL_SCALE - volt_pos;
            pidc_pkg::SRC_CURR_REV: fb_raw = pidc_pkg::FULL_SCALE - curr_scaled;
        endcase
    end

    pidc_filter u_filter
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .sample_tick(sample_tick),
        .filter_time(filter_reg),
        .raw_value(fb_raw),
        .filtered_value(fb_filt)
    );

    // ------------------------------------------------------------
    // three-term arithmetic
    // ------------------------------------------------------------
    logic active_now;
    logic signed [12:0] dev_now;
    logic signed [12:0] dev_prev_reg;
    logic signed [12:0] deviation_reg;
    logic signed [31:0] integ_acc_reg;
    logic signed [31:0] acc_next;
    logic [22:0] ti_den;
    logic signed [31:0] iterm;
    logic signed [13:0] dev_delta;
    logic [13:0] d_scale;
    logic signed [31:0] dterm;
    logic signed [31:0] term_sum;
    logic signed [31:0] pid_sum;
    logic [11:0] demand_next;

    assign active_now = ctrl_reg[pidc_pkg::CTRL_ENABLE_BIT] && !motor2_select;

    always_comb
    begin
        dev_now = $signed({1'b0, target_now}) - $signed({1'b0, fb_filt});
        ti_den = 23'(itime_reg * 23'd100);
        acc_next = sat32(integ_acc_reg + 32'(dev_now), pidc_pkg::ACC_LIMIT);
        iterm = (itime_reg == 16'h0000) ? 32'sh0 : integ_acc_reg / $signed({9'h000, ti_den});
        dev_delta = 14'(dev_now) - 14'(dev_prev_reg);
        d_scale = 14'(dtime_reg * 16'(pidc_pkg::DERIV_SCALE));
        dterm = 32'(dev_delta) * $signed({18'h00000, d_scale});
        term_sum = sat32(32'(dev_now) + iterm + dterm, pidc_pkg::SUM_LIMIT);
        // divisor kept signed so a negative sum is not divided as a huge unsigned value
        pid_sum = ($signed({16'h0000, gain_reg}) * term_sum) / $signed(32'(pidc_pkg::PERCENT_DIV));
        if (output_reverse)
            pid_sum = -pid_sum;
        if (!active_now)
            demand_next = target_now;
        else if (pid_sum < 32'sh0)
            demand_next = 12'h000;
        else if (pid_sum > $signed(32'(pidc_pkg::FULL_SCALE)))
            demand_next = pidc_pkg::FULL_SCALE;
        else
            demand_next = pid_sum[11:0];
    end

    // integral accumulator: held clear while disabled or inhibited
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            integ_acc_reg <= 32'sh0;
        else if (!active_now || itime_reg == 16'h0000)
            integ_acc_reg <= 32'sh0;
        else if (calc_strobe_reg)
            integ_acc_reg <= acc_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            dev_prev_reg <= 13'sh0;
            deviation_reg <= 13'sh0;
        end
        else if (calc_strobe_reg)
        begin
            dev_prev_reg <= dev_now;
            deviation_reg <= dev_now;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            freq_demand <= 12'h000;
            pid_active <= 1'b0;
        end
        else if (calc_strobe_reg)
        begin
            freq_demand <= demand_next;
            pid_active <= active_now;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic clamp_hi_reg;
    logic clamp_lo_reg;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            clamp_hi_reg <= 1'b0;
            clamp_lo_reg <= 1'b0;
        end
        else if (calc_strobe_reg)
        begin
            clamp_hi_reg <= active_now && pid_sum > $signed(32'(pidc_pkg::FULL_SCALE));
            clamp_lo_reg <= active_now && pid_sum < 32'sh0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                pidc_pkg::REG_CTRL: reg_rdata <= ctrl_reg;
                pidc_pkg::REG_GAIN: reg_rdata <= gain_reg;
                pidc_pkg::REG_ITIME: reg_rdata <= itime_reg;
                pidc_pkg::REG_DTIME: reg_rdata <= dtime_reg;
                pidc_pkg::REG_FILTER: reg_rdata <= filter_reg;
                pidc_pkg::REG_KEYPAD: reg_rdata <= keypad_reg;
                pidc_pkg::REG_DISP_A: reg_rdata <= disp_a_reg;
                pidc_pkg::REG_DISP_B: reg_rdata <= disp_b_reg;
                pidc_pkg::REG_STATUS: reg_rdata <= {13'h0000, clamp_lo_reg, clamp_hi_reg, pid_active};
                pidc_pkg::REG_DEVIATION: reg_rdata <= 16'(deviation_reg);
                pidc_pkg::REG_DEMAND: reg_rdata <= {4'h0, freq_demand};
                pidc_pkg::REG_DISP_TARGET: reg_rdata <= display(target_now, disp_a_reg, disp_b_reg);
                pidc_pkg::REG_DISP_FEEDBACK: reg_rdata <= display(fb_filt, disp_a_reg, disp_b_reg);
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_deviation_sign: assert property (@(posedge clk_sys) disable iff (reset)
        calc_strobe_reg |=> deviation_reg == $past(13'($signed({1'b0, target_now}) - $signed({1'b0, fb_filt}))))
        else $error("deviation is not target minus feedback");

    a_negative_clip: assert property (@(posedge clk_sys) disable iff (reset)
        feedback_source_select == pidc_pkg::SRC_VOLT_FWD && voltage_feedback_input < 13'sh0 |-> fb_raw == 12'h000)
        else $error("negative voltage feedback was not treated as zero");

    a_voltage_reverse: assert property (@(posedge clk_sys) disable iff (reset)
        feedback_source_select == pidc_pkg::SRC_VOLT_REV && !voltage_feedback_input[12]
        |-> fb_raw == 12'(pidc_pkg::FULL_SCALE - voltage_feedback_input[11:0]))
        else $error("reverse voltage feedback mapping wrong");

    a_target_keypad: assert property (@(posedge clk_sys) disable iff (reset)
        target_select |-> target_now == keypad_reg[11:0])
        else $error("keypad target not selected");

    a_motor2_inhibit: assert property (@(posedge clk_sys) disable iff (reset)
        calc_strobe_reg && motor2_select |=> !pid_active && freq_demand == $past(target_now))
        else $error("controller not inhibited with second motor set");

    a_integral_off: assert property (@(posedge clk_sys) disable iff (reset)
        itime_reg == 16'h0000 |=> integ_acc_reg == 32'sh0)
        else $error("integral kept state while disabled");

    a_reverse_sense: assert property (@(posedge clk_sys) disable iff (reset)
        calc_strobe_reg && active_now && output_reverse && itime_reg == 16'h0000
        && dtime_reg == 16'h0000 && dev_now > 13'sh0 |=> freq_demand == 12'h000)
        else $error("reverse sense did not lower demand");

    a_clamp_low: assert property (@(posedge clk_sys) disable iff (reset)
        calc_strobe_reg && active_now && pid_sum < 32'sh0 |=> freq_demand == 12'h000 ##1 clamp_lo_reg [*2])
        else $error("negative sum not clamped to zero");

    a_proportional: assert property (@(posedge clk_sys) disable iff (reset)
        calc_strobe_reg && active_now && !output_reverse && gain_reg == 16'h0064 && itime_reg == 16'h0000
        && dtime_reg == 16'h0000 && dev_now >= 13'sh0 |=> freq_demand == $past(12'(dev_now)))
        else $error("unity gain does not pass deviation");
endmodule : pidc_controller

// ---- logic/pidc_pkg.sv ----
// constants shared by the process controller files
package pidc_pkg;
    // ------------------------------------------------------------
    // value widths and scaling
    // ------------------------------------------------------------
    localparam int VAL_W = 12;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [11:0] FULL_SCALE = 12'hfff;
    localparam logic [11:0] CURRENT_ZERO_CODE = 12'h333;
    localparam logic [11:0] CURRENT_SPAN = 12'hccc;
    localparam logic [6:0] PERCENT_DIV = 7'h64;
    localparam logic [3:0] DERIV_SCALE = 4'ha;
    localparam logic signed [31:0] SUM_LIMIT = 32'sh000fffff;
    localparam logic signed [31:0] ACC_LIMIT = 32'sh3fffffff;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_TIME_NS = 1000000;
    localparam int SAMPLE_CYCLES = SAMPLE_TIME_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_GAIN = 4'h1;
    localparam logic [3:0] REG_ITIME = 4'h2;
    localparam logic [3:0] REG_DTIME = 4'h3;
    localparam logic [3:0] REG_FILTER = 4'h4;
    localparam logic [3:0] REG_KEYPAD = 4'h5;
    localparam logic [3:0] REG_DISP_A = 4'h6;
    localparam logic [3:0] REG_DISP_B = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_DEVIATION = 4'h9;
    localparam logic [3:0] REG_DEMAND = 4'ha;
    localparam logic [3:0] REG_DISP_TARGET = 4'hb;
    localparam logic [3:0] REG_DISP_FEEDBACK = 4'hc;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_REVERSE_BIT = 2;
    localparam int CTRL_ENABLE_BIT = 3;
    localparam logic [1:0] SRC_VOLT_FWD = 2'h0;
    localparam logic [1:0] SRC_CURR_FWD = 2'h1;
    localparam logic [1:0] SRC_VOLT_REV = 2'h2;
    localparam logic [1:0] SRC_CURR_REV = 2'h3;
    // ------------------------------------------------------------
    // reset values and write ranges
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h0064;
    localparam logic [15:0] GAIN_MIN = 16'h0001;
    localparam logic [15:0] GAIN_MAX = 16'h03e8;
    localparam logic [15:0] ITIME_RESET = 16'h0000;
    localparam logic [15:0] ITIME_MAX = 16'h8ca0;
    localparam logic [15:0] DTIME_RESET = 16'h0000;
    localparam logic [15:0] DTIME_MAX = 16'h03e8;
    localparam logic [15:0] FILTER_RESET = 16'h0000;
    localparam logic [15:0] FILTER_MAX = 16'h0258;
    localparam logic [15:0] DISP_A_RESET = 16'h1000;
    localparam logic [15:0] DISP_B_RESET = 16'h0000;
endpackage : pidc_pkg

// ---- logic/pidc_filter.sv ----
// first order low-pass filter for the feedback value
`timescale 1ns/1ns
module pidc_filter
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // control
    input wire logic sample_tick,
    input wire logic [15:0] filter_time,
    // data
    input wire logic [11:0] raw_value,
    output logic [11:0] filtered_value
);
    // ------------------------------------------------------------
    // state holds 12 integer and 16 fraction bits
    // ------------------------------------------------------------
    logic [27:0] state_reg;
    logic [27:0] state_next;
    logic [16:0] denom;
    logic signed [29:0] diff;
    logic signed [29:0] step;

    // time constant in 0.1 s over a 1 ms step gives alpha 1/(t*100+1)
    always_comb
    begin
        denom = 17'(filter_time * 17'd100) + 17'h00001;
        diff = $signed({2'b00, raw_value, 16'h0000}) - $signed({2'b00, state_reg});
        step = diff / $signed({13'h0000, denom});
        state_next = state_reg + step[27:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state_reg <= 28'h0000000;
        else if (sample_tick)
            state_reg <= state_next;
    end

    assign filtered_value = state_reg[27:16];

    a_filter_bypass: assert property (@(posedge clk_sys) disable iff (reset)
        sample_tick && filter_time == 16'h0000 |=> filtered_value == $past(raw_value))
        else $error("filter with zero time did not pass input through");
endmodule : pidc_filter

// ---- test/pidc_sensor_model.sv ----
// process sensor model driving the analog feedback codes
`timescale 1ns/1ns
module pidc_sensor_model
(
    // clock
    input wire logic clk_sys,
    // process state
    input wire logic [11:0] process_value,
    input wire logic wire_fault,
    // analog codes
    output logic signed [12:0] volt_code,
    output logic signed [12:0] curr_code
);
    // codes settle one clock after the process moves
    always_ff @(posedge clk_sys)
    begin
        if (wire_fault)
        begin
            // broken loop: negative volts, current under 4 mA
            volt_code <= -13'sh0200;
            curr_code <= 13'sh00a0;
        end
        else
        begin
            volt_code <= {1'b0, process_value};
            curr_code <= 13'(25'(process_value) * 25'h0000ccc / 25'h0000fff) + 13'sh0333;
        end
    end
endmodule : pidc_sensor_model

// ---- test/pid_process_controller_tb_top.sv ----
// self-checking bench for the process controller
`timescale 1ns/1ns
module pid_process_controller_tb_top;
    localparam int SC = 16;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [11:0] process_value = 12'h000;
    logic wire_fault = 1'b0;
    logic signed [12:0] volt_code;
    logic signed [12:0] curr_code;
    logic [11:0] primary_source = 12'h000;
    logic target_select = 1'b0;
    logic motor2_select = 1'b0;
    logic [11:0] freq_demand;
    logic pid_active;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] rd;
    logic [11:0] peak;
    logic [15:0] reset_vals [8] = '{16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1000, 16'h0000};
    logic [3:0] clip_addr [7] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'h5};
    logic [15:0] clip_out [7] = '{16'h0001, 16'h03e8, 16'h8ca0, 16'h03e8, 16'h0258, 16'h000f, 16'h0fff};

    always #5 clk_sys = ~clk_sys;

    pidc_sensor_model sensor
    (
        .clk_sys(clk_sys),
        .process_value(process_value),
        .wire_fault(wire_fault),
        .volt_code(volt_code),
        .curr_code(curr_code)
    );

    pidc_controller #(.SAMPLE_CYCLES(SC)) dut
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .voltage_feedback_input(volt_code),
        .current_feedback_input(curr_code),
        .primary_frequency_source(primary_source),
        .target_select(target_select),
        .motor2_select(motor2_select),
        .freq_demand(freq_demand),
        .pid_active(pid_active)
    );

    // ------------------------------------------------------------
    // access and check tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] addr, output logic [15:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        data = reg_rdata;
    endtask : reg_read

    task automatic settle();
        repeat (4 * SC) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic steady(input logic [3:0] ctrl, input logic [15:0] gain, input logic [11:0] pv,
        input logic [11:0] tgt, input logic [11:0] exp_d, input logic [15:0] exp_dev);
        reg_write(4'h0, {12'h000, ctrl});
        reg_write(4'h1, gain);
        process_value <= pv;
        primary_source <= tgt;
        settle();
        check({4'h0, freq_demand}, {4'h0, exp_d});
        check({15'h0000, pid_active}, {15'h0000, ctrl[3] & ~motor2_select});
        if (ctrl[3] && !motor2_select)
        begin
            reg_read(4'h9, rd);
            check(rd, exp_dev);
        end
    endtask : steady

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            reg_read(4'(i), rd);
            check(rd, reset_vals[i]);
        end
        reg_read(4'hd, rd);
        check(rd, 16'h0000);
        for (int i = 0; i < 7; i++)
        begin
            reg_write(clip_addr[i], (i == 0) ? 16'h0000 : 16'hffff);
            reg_read(clip_addr[i], rd);
            check(rd, clip_out[i]);
        end
        reg_write(4'h2, 16'h0000);
        reg_write(4'h3, 16'h0000);
        reg_write(4'h4, 16'h0000);
        steady(4'h8, 16'h0064, 12'h300, 12'h800, 12'h500, 16'h0500);
        steady(4'ha, 16'h0064, 12'hc00, 12'h800, 12'h401, 16'h0401);
        steady(4'h9, 16'h0064, 12'h000, 12'h400, 12'h400, 16'h0400);
        steady(4'h9, 16'h0064, 12'hfff, 12'hfff, 12'h000, 16'h0000);
        steady(4'hb, 16'h0064, 12'hfff, 12'h400, 12'h400, 16'h0400);
        steady(4'hb, 16'h0064, 12'h000, 12'hfff, 12'h000, 16'h0000);
        wire_fault <= 1'b1;
        steady(4'h8, 16'h0064, 12'h000, 12'h600, 12'h600, 16'h0600);
        steady(4'h9, 16'h0064, 12'h000, 12'h600, 12'h600, 16'h0600);
        wire_fault <= 1'b0;
        steady(4'hc, 16'h0064, 12'h300, 12'h800, 12'h000, 16'h0500);
        reg_read(4'h8, rd);
        check(rd, 16'h0005);
        @(negedge clk_sys);
        check(reg_rdata, 16'h0000);
        steady(4'hc, 16'h0064, 12'h300, 12'h100, 12'h200, 16'hfe00);
        steady(4'h8, 16'h03e8, 12'h300, 12'h800, 12'hfff, 16'h0500);
        reg_read(4'ha, rd);
        check(rd, 16'h0fff);
        reg_read(4'h8, rd);
        check(rd, 16'h0003);
        steady(4'h8, 16'h0032, 12'h300, 12'h800, 12'h280, 16'h0500);
        steady(4'h8, 16'h0001, 12'h300, 12'h800, 12'h00c, 16'h0500);
        steady(4'h8, 16'h0064, 12'h800, 12'h100, 12'h000, 16'hf900);
        steady(4'h0, 16'h0064, 12'h300, 12'h800, 12'h800, 16'h0000);
        motor2_select <= 1'b1;
        steady(4'h8, 16'h0064, 12'h300, 12'h800, 12'h800, 16'h0000);
        motor2_select <= 1'b0;
        reg_write(4'h5, 16'h0600);
        target_select <= 1'b1;
        steady(4'h8, 16'h0064, 12'h000, 12'h200, 12'h600, 16'h0600);
        target_select <= 1'b0;
        reg_write(4'h6, 16'h2000);
        reg_write(4'h7, 16'h0005);
        steady(4'h8, 16'h0064, 12'h100, 12'h300, 12'h200, 16'h0200);
        reg_read(4'hb, rd);
        check(rd, 16'h0605);
        reg_read(4'hc, rd);
        check(rd, 16'h0205);
        steady(4'h8, 16'h0064, 12'h700, 12'h800, 12'h100, 16'h0100);
        reg_write(4'h2, 16'h0001);
        repeat (20 * SC) @(negedge clk_sys);
        check({15'h0000, freq_demand > 12'h100 && freq_demand < 12'h140}, 16'h0001);
        reg_write(4'h2, 16'h0000);
        settle();
        check({4'h0, freq_demand}, 16'h0100);
        steady(4'h8, 16'h0064, 12'h800, 12'h800, 12'h000, 16'h0000);
        reg_write(4'h3, 16'h0001);
        process_value <= 12'h700;
        peak = 12'h000;
        repeat (4 * SC)
        begin
            @(negedge clk_sys);
            peak = (freq_demand > peak) ? freq_demand : peak;
        end
        check({4'h0, peak}, 16'h0b00);
        check({4'h0, freq_demand}, 16'h0100);
        reg_write(4'h3, 16'h0000);
        steady(4'h8, 16'h0064, 12'h800, 12'h800, 12'h000, 16'h0000);
        reg_write(4'h4, 16'h0064);
        process_value <= 12'h000;
        settle();
        check({15'h0000, freq_demand < 12'h020}, 16'h0001);
        reg_write(4'h4, 16'h0000);
        settle();
        check({4'h0, freq_demand}, 16'h0800);
        report_and_stop();
    end
endmodule : pid_process_controller_tb_top
